// ---- shared/cfg_defines.vh ----
`ifndef CFG_DEFINES_VH
`define CFG_DEFINES_VH

// register offsets within the peripheral space
`define CFG_ADDR_W 24
`define CFG_OFS_TLOCK 24'h110000
`define CFG_OFS_CTRL 24'h110004
`define CFG_OFS_LPWR 24'h110007
`define CFG_OFS_RSTCFG 24'h110008
`define CFG_OFS_PARTID 24'h11000A
`define CFG_OFS_UNIMP 24'h110010

// reset values
`define CFG_CTRL_RST 16'h0001
`define CFG_LPWR_RST 8'h00
`define CFG_RSTCFG_RST 16'h0000
`define CFG_BME_RST 1'h0
`define CFG_BMT_RST 3'h1
`define CFG_SIZE_PINS_ENABLE_RST 1'h0
`define CFG_PROC_STATUS_PINS_ENABLE_RST 1'h0
`define CFG_DEF_DRIVE 1'h0
`define CFG_DEF_MODE 1'h0

// test lock key
`define CFG_TLOCK_KEY 16'h0000

// control register fields
`define CFG_SIZE_PINS_ENABLE_BIT 6
`define CFG_PROC_STATUS_PINS_ENABLE_BIT 5
`define CFG_BME_BIT 3
`define CFG_BMT_MSB 2
`define CFG_BMT_LSB 0

// reset configuration fields and override data pins
`define CFG_RC_DRIVE_BIT 5
`define CFG_RC_MODE_BIT 0
`define CFG_PIN_DRIVE 5
`define CFG_PIN_MODE 0

// bus watch timeout for code 000, in system clocks
`define CFG_BMT_MAX 17'h10000

// reset_output negation to pin drive, in output clock cycles
`define CFG_OE_HOLD_OCLK 1

`endif

// ---- verif/cfg_checker.sv ----
`timescale 1ns/1ns
`include "cfg_defines.vh"
module cfg_checker
#(
    parameter [15:0] PART_ID = 16'h0C35
)
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic BUS_SEL,
    input wire logic BUS_WR,
    input wire logic BUS_SIZE16,
    input wire logic BUS_SUPV,
    input wire logic [23:0] BUS_ADDR,
    input wire logic [15:0] BUS_RDATA,
    input wire logic BUS_ACK,
    input wire logic BUS_TERR,
    // reset configuration
    input wire logic RESET_OUTPUT,
    input wire logic RESET_CONFIG_SELECT_N,
    input wire logic [15:0] DATA_PINS_IN,
    input wire logic DATA_PINS_OE_N,
    input wire logic PAD_DRIVE_STRENGTH,
    input wire logic MASTER_MODE,
    // modes and write-once outputs
    input wire logic DEBUG_MODE,
    input wire logic TEST_ACTIVE,
    input wire logic BUS_WATCH_ENABLE,
    // bus watch
    input wire logic [2:0] BUS_WATCH_TIMEOUT,
    input wire logic [16:0] BUS_WATCH_CYCLES
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    wire rd = BUS_SEL && !BUS_WR && BUS_SUPV && BUS_SIZE16;
    chk_user_terr: assert property (
        BUS_SEL && !BUS_SUPV |=> BUS_TERR && !BUS_ACK)
        else $error("user access not refused");
    chk_unimp_terr: assert property (
        BUS_SEL && BUS_ADDR == `CFG_OFS_UNIMP |=> BUS_TERR && !BUS_ACK)
        else $error("unimplemented access not refused");
    chk_id_read: assert property (
        rd && BUS_ADDR == `CFG_OFS_PARTID |=> BUS_ACK && BUS_RDATA == PART_ID)
        else $error("part id wrong");
    chk_rcfg_read: assert property (
        rd && BUS_ADDR == `CFG_OFS_RSTCFG && !RESET_OUTPUT |=>
        BUS_RDATA == {10'h000, PAD_DRIVE_STRENGTH, 4'h0, MASTER_MODE})
        else $error("reset config read wrong");
    chk_pins_held: assert property (
        RESET_OUTPUT |=> DATA_PINS_OE_N [*2])
        else $error("data pins driven too early");
    chk_strap_take: assert property (
        RESET_OUTPUT && !RESET_CONFIG_SELECT_N |=>
        PAD_DRIVE_STRENGTH == $past(DATA_PINS_IN[5]) && MASTER_MODE == $past(DATA_PINS_IN[0]))
        else $error("strap not captured");
    chk_strap_dflt: assert property (
        RESET_OUTPUT && RESET_CONFIG_SELECT_N |=> !PAD_DRIVE_STRENGTH && !MASTER_MODE)
        else $error("default config not used");
    chk_watch_cyc: assert property (
        1'b1 |-> BUS_WATCH_CYCLES == (`CFG_BMT_MAX >> $past(BUS_WATCH_TIMEOUT)))
        else $error("timeout cycles wrong");
    chk_wonce_cause: assert property (
        !$stable(BUS_WATCH_TIMEOUT) |-> BUS_ACK && $past(BUS_WR))
        else $error("timeout changed without write");
    // written state rebuilt from the bus as the rules define it
    wire ctrl_wr = BUS_SEL && BUS_WR && BUS_SUPV && BUS_SIZE16 && BUS_ADDR == `CFG_OFS_CTRL;
    logic wlock_r;
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            wlock_r <= 1'b0;
        else if (ctrl_wr)
            wlock_r <= !(DEBUG_MODE || TEST_ACTIVE);
    end
    chk_wonce_lock: assert property (
        ctrl_wr && wlock_r && !DEBUG_MODE && !TEST_ACTIVE |=>
        $stable(BUS_WATCH_TIMEOUT) && $stable(BUS_WATCH_ENABLE))
        else $error("write-once field rewritten");
    cov_test_wr: cover property (ctrl_wr && TEST_ACTIVE);
    cov_strap: cover property (RESET_OUTPUT && !RESET_CONFIG_SELECT_N ##1 !RESET_OUTPUT);
    cov_unimp: cover property (BUS_SEL && BUS_ADDR == `CFG_OFS_UNIMP ##1 BUS_TERR);
    cov_code7: cover property (BUS_WATCH_TIMEOUT == 3'h7);
endmodule
bind cfg_regs cfg_checker #(.PART_ID(PART_ID)) i_chk (.*);

// ---- verif/cfg_ovr_model.sv ----
`timescale 1ns/1ns
module cfg_ovr_model
(
    // clock and reset output
    input wire logic clk,
    input wire logic reset_out,
    // levels and pins
    input wire logic [15:0] strap,
    output logic [15:0] pins
);
    logic hold_r = 1'b0;
    logic [15:0] last_r = 16'h0000;
    // released pins float: show a changing pattern
    assign pins = (reset_out || hold_r) ? strap : ~last_r;
    always @(posedge clk)
    begin
        hold_r <= reset_out;
        last_r <= pins;
    end
endmodule

// ---- verif/test_chip_configuration_regs.sv ----
`timescale 1ns/1ns
`include "cfg_defines.vh"
module test_chip_configuration_regs;
    // arbitrary value
    localparam logic [15:0] ID = 16'h5A3C;
    logic ref_clk = 1'b0, sys_rst = 1'b1, sel = 1'b0, wr = 1'b0, sz = 1'b1, supv = 1'b1;
    logic dbg = 1'b0, tst = 1'b0, ro = 1'b0, rsn = 1'b1, wo = 1'b0, lk = 1'b0, fr = 1'b0;
    logic [23:0] adr = 24'h000000;
    logic [15:0] wd = 16'h0000, strap = 16'h0000, ctl_e, rdata, pins;
    logic [31:0] rs = 32'h96154C7B;
    logic ack, terr, oen, size_pins_enable, psen, bwe, pad, mm, ta;
    logic [2:0] bwt;
    logic [16:0] bwc;
    logic [7:0] lp;
    logic [1:0] e;
    int miscompares = 0, compares = 0, cyc = 0, i;
    cfg_regs #(.PART_ID(ID)) i_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS_SEL(sel),
        .BUS_WR(wr), .BUS_SIZE16(sz), .BUS_SUPV(supv), .BUS_ADDR(adr), .BUS_WDATA(wd),
        .BUS_RDATA(rdata), .BUS_ACK(ack), .BUS_TERR(terr), .DEBUG_MODE(dbg), .TEST_MODE(tst),
        .RESET_OUTPUT(ro), .RESET_CONFIG_SELECT_N(rsn), .DATA_PINS_IN(pins),
        .DATA_PINS_OE_N(oen), .SIZE_PINS_ENABLE(size_pins_enable), .PROC_STATUS_PINS_ENABLE(psen),
        .BUS_WATCH_ENABLE(bwe), .BUS_WATCH_TIMEOUT(bwt), .BUS_WATCH_CYCLES(bwc),
        .PAD_DRIVE_STRENGTH(pad), .MASTER_MODE(mm), .TEST_ACTIVE(ta), .LOW_POWER_CTRL(lp));
    cfg_ovr_model i_ovr (.clk(ref_clk), .reset_out(ro), .strap(strap), .pins(pins));
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    function logic [16:0] cyc_of(input logic [2:0] c);
        return `CFG_BMT_MAX >> c;
    endfunction
    function logic [15:0] rnd();
        rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return rs[15:0];
    endfunction
    task wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [16:0] x, input logic [16:0] v);
        compares++;
        if (v !== x)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, v);
        end
    endtask
    task rst();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        ctl_e = `CFG_CTRL_RST;
        wo = 1'b0;
        lk = 1'b0;
    endtask
    task acc(input logic w, s, input logic [23:0] a, input logic [15:0] d,
        input logic [1:0] r, input logic [15:0] x);
        @(posedge ref_clk);
        sel <= 1'b1;
        wr <= w;
        supv <= s;
        adr <= a;
        wd <= d;
        sz <= (a != `CFG_OFS_LPWR);
        @(posedge ref_clk);
        sel <= 1'b0;
        #1 chk("resp", r, {terr, ack});
        if (!w)
            chk("rdata", x, rdata);
    endtask
    task wctl(input logic [15:0] d);
        acc(1, 1, `CFG_OFS_CTRL, d, 2'b01, 0);
        fr = dbg || (tst && !lk);
        if (fr || !wo)
            ctl_e[3:0] = d[3:0];
        ctl_e[6:5] = d[6:5];
        wo = !fr;
        chk("size_pins_enable", ctl_e[6], size_pins_enable);
        chk("psen", ctl_e[5], psen);
        chk("bwe", ctl_e[3], bwe);
        @(posedge ref_clk);
        #1 chk("bwc", cyc_of(ctl_e[2:0]), bwc);
        acc(0, 1, `CFG_OFS_CTRL, 0, 2'b01, ctl_e);
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    initial
    begin
        rst();
        acc(0, 1, `CFG_OFS_CTRL, 0, 2'b01, 16'h0001);
        acc(0, 1, `CFG_OFS_RSTCFG, 0, 2'b01, 16'h0000);
        acc(1, 1, `CFG_OFS_PARTID, 16'hFFFF, 2'b01, 0);
        acc(0, 1, `CFG_OFS_PARTID, 0, 2'b01, ID);
        acc(0, 0, `CFG_OFS_CTRL, 0, 2'b10, 0);
        acc(1, 1, `CFG_OFS_UNIMP, 16'h0041, 2'b10, 0);
        acc(0, 1, `CFG_OFS_CTRL, 0, 2'b01, 16'h0001);
        acc(1, 1, `CFG_OFS_LPWR, 16'h00A5, 2'b01, 0);
        chk("lp", 8'hA5, lp);
        $display("map test done");
        for (i = 0; i < 4; i++)
            wctl(rnd() & 16'h006F);
        @(posedge ref_clk);
        dbg <= 1'b1;
        for (i = 0; i < 8; i++)
            wctl({12'h000, 1'b1, i[2:0]});
        @(posedge ref_clk);
        dbg <= 1'b0;
        #1 chk("bwt", 3'h7, bwt);
        wctl(16'h0042);
        wctl(16'h0005);
        rst();
        wctl(rnd() & 16'h006F);
        $display("write-once test done");
        @(posedge ref_clk);
        tst <= 1'b1;
        @(posedge ref_clk);
        #1 chk("test", 1, ta);
        wctl(16'h000B);
        acc(1, 1, `CFG_OFS_TLOCK, 16'h0001, 2'b01, 0);
        chk("test", 1, ta);
        acc(1, 1, `CFG_OFS_TLOCK, 16'h0000, 2'b01, 0);
        lk = 1'b1;
        chk("test", 0, ta);
        wctl(16'h0064);
        wctl(16'h0003);
        @(posedge ref_clk);
        tst <= 1'b0;
        $display("test lock test done");
        for (i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            ro <= 1'b1;
            rsn <= i[0];
            strap <= rnd();
            repeat (3) @(posedge ref_clk);
            #1 chk("oe", 1, oen);
            @(posedge ref_clk);
            ro <= 1'b0;
            rsn <= 1'b1;
            @(posedge ref_clk);
            #1 chk("oe", 1, oen);
            @(posedge ref_clk);
            #1 chk("oe", 0, oen);
            e = i[0] ? 2'b00 : {strap[5], strap[0]};
            chk("pad", e[1], pad);
            chk("mode", e[0], mm);
            acc(0, 1, `CFG_OFS_RSTCFG, 0, 2'b01, {10'h000, e[1], 4'h0, e[0]});
        end
        $display("strap test done");
        wrap_up();
    end
endmodule

// ---- verilog/cfg_regs.v ----
// Operation
// - write-once bits always read back; later writes ignored outside debug or test
// - debug accepts every write-once write; field stays writable after debug
// - after debug, logic runs from current register values, no reload
// - control register: 16 bits at 0x110004, reset 0x0001, supervisor only
// - reset configuration register: 16-bit read-only at 0x110008, reset 0x0000
// - part identification: 16-bit read-only at 0x11000A, fixed code
// - access to 0x110010 changes nothing and ends with transfer error
// - writing 0x0000 to the reserved location locks out test features
// - control bit 6 enables the transfer-size pin function
// - control bit 5 enables processor status and debug data pins
// - write-once bit 3 enables bus watch on external cycles
// - write-once bits 2..0 pick bus watch timeout, 65536 down to 512
// - reset-config pin low in reset: configuration taken from data pins
// - reset-config pin high in reset: defaults used, data pins ignored
// - data pins stay inputs until one output clock after reset ends
// - reset config bit 5 reports drive strength, bit 0 reports chip mode
`timescale 1ns/1ns
`include "cfg_defines.vh"

module cfg_regs
#(
    // arbitrary neutral identification value
    parameter [15:0] PART_ID = 16'h0C35,
    // reference clocks per output clock period
    parameter OCLK_DIV = 1
)
(
    // clock and reset
    input wire REF_CLK,
    input wire SYS_RST,
    // register access port
    input wire BUS_SEL,
    input wire BUS_WR,
    input wire BUS_SIZE16,
    input wire BUS_SUPV,
    input wire [23:0] BUS_ADDR,
    input wire [15:0] BUS_WDATA,
    output wire [15:0] BUS_RDATA,
    output wire BUS_ACK,
    output wire BUS_TERR,
    // operating modes
    input wire DEBUG_MODE,
    input wire TEST_MODE,
    // reset configuration
    input wire RESET_OUTPUT,
    input wire RESET_CONFIG_SELECT_N,
    input wire [15:0] DATA_PINS_IN,
    output wire DATA_PINS_OE_N,
    // configuration outputs
    output wire SIZE_PINS_ENABLE,
    output wire PROC_STATUS_PINS_ENABLE,
    output wire BUS_WATCH_ENABLE,
    output wire [2:0] BUS_WATCH_TIMEOUT,
    output wire [16:0] BUS_WATCH_CYCLES,
    output wire PAD_DRIVE_STRENGTH,
    output wire MASTER_MODE,
    output wire TEST_ACTIVE,
    output wire [7:0] LOW_POWER_CTRL
);

    // pins stay released this many reference clocks after reset_output falls
    localparam HOLD_CYC = `CFG_OE_HOLD_OCLK * OCLK_DIV;

    // decode codes
    localparam SEL_NONE = 3'h0;
    localparam SEL_CTRL = 3'h1;
    localparam SEL_LPWR = 3'h2;
    localparam SEL_RCFG = 3'h3;
    localparam SEL_PID = 3'h4;
    localparam SEL_TLCK = 3'h5;

    reg size_en_r;
    reg pst_en_r;
    reg [7:0] lpwr_r;
    reg tlock_r;
    reg [15:0] rdata_r;
    reg ack_r;
    reg terr_r;
    reg [15:0] rdata_nxt;
    reg [16:0] cycles_r;
    reg [15:0] ctrl_val;
    reg [15:0] rcfg_val;
    reg ack_nxt;
    reg terr_nxt;

    wire [2:0] sel;
    wire acc_ok;
    wire wr_ok;
    wire free;
    wire bus_watch_enable;
    wire [2:0] bus_watch_timeout;
    wire drive_full;
    wire master;
    wire ctrl_wr;
    wire lpwr_wr;
    wire tlock_wr;

    // map offset and access size to a register; wrong size is unmapped
    function [2:0] cfg_decode;
        input [23:0] addr;
        input size16;
        begin
            cfg_decode = SEL_NONE;
            if (addr == `CFG_OFS_CTRL && size16)
                cfg_decode = SEL_CTRL;
            else if (addr == `CFG_OFS_LPWR && !size16)
                cfg_decode = SEL_LPWR;
            else if (addr == `CFG_OFS_RSTCFG && size16)
                cfg_decode = SEL_RCFG;
            else if (addr == `CFG_OFS_PARTID && size16)
                cfg_decode = SEL_PID;
            else if (addr == `CFG_OFS_TLOCK && size16)
                cfg_decode = SEL_TLCK;
        end
    endfunction

    // timeout halves with each code step
    function [16:0] cfg_bmt_cycles;
        input [2:0] code;
        begin
            cfg_bmt_cycles = `CFG_BMT_MAX >> code;
        end
    endfunction

    assign sel = cfg_decode(BUS_ADDR, BUS_SIZE16);
    // user mode and unmapped offsets (0x110010 among them) touch nothing
    assign acc_ok = BUS_SEL && BUS_SUPV && (sel != SEL_NONE);
    assign wr_ok = acc_ok && BUS_WR;
    assign TEST_ACTIVE = TEST_MODE && !tlock_r;
    assign free = DEBUG_MODE || TEST_ACTIVE;
    // one decode per target keeps the write strobes consistent
    assign ctrl_wr = wr_ok && sel == SEL_CTRL;
    assign lpwr_wr = wr_ok && sel == SEL_LPWR;
    assign tlock_wr = wr_ok && sel == SEL_TLCK && BUS_WDATA == `CFG_TLOCK_KEY;

    // bits 3 and 2..0 share a strobe but keep separate written flags
    cfg_wonce
    #(
        .W(1),
        .RST_VAL(`CFG_BME_RST)
    )
    u_bme
    (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .wr(ctrl_wr),
        .free(free),
        .wdata(BUS_WDATA[`CFG_BME_BIT]),
        .q(bus_watch_enable)
    );

    cfg_wonce
    #(
        .W(3),
        .RST_VAL(`CFG_BMT_RST)
    )
    u_bmt
    (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .wr(ctrl_wr),
        .free(free),
        .wdata(BUS_WDATA[`CFG_BMT_MSB:`CFG_BMT_LSB]),
        .q(bus_watch_timeout)
    );

    cfg_strap
    #(
        .HOLD_CYC(HOLD_CYC)
    )
    u_strap
    (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .reset_out(RESET_OUTPUT),
        .reset_config_select_n(RESET_CONFIG_SELECT_N),
        .data_in(DATA_PINS_IN),
        .drive_full(drive_full),
        .master_mode(master),
        .data_oe_n(DATA_PINS_OE_N)
    );

    // plain read/write control bits
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            size_en_r <= `CFG_SIZE_PINS_ENABLE_RST;
            pst_en_r <= `CFG_PROC_STATUS_PINS_ENABLE_RST;
        end
        else if (ctrl_wr)
        begin
            size_en_r <= BUS_WDATA[`CFG_SIZE_PINS_ENABLE_BIT];
            pst_en_r <= BUS_WDATA[`CFG_PROC_STATUS_PINS_ENABLE_BIT];
        end
    end

    // low-power byte: stored only, its fields act elsewhere
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            lpwr_r <= `CFG_LPWR_RST;
        else if (lpwr_wr)
            lpwr_r <= BUS_WDATA[7:0];
    end

    // test lock: once set only reset reopens test features
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            tlock_r <= 1'b0;
        else if (tlock_wr)
            tlock_r <= 1'b1;
    end

    // live values: nothing reloads when debug ends
    always @*
    begin
        ctrl_val = 16'h0000;
        ctrl_val[`CFG_SIZE_PINS_ENABLE_BIT] = size_en_r;
        ctrl_val[`CFG_PROC_STATUS_PINS_ENABLE_BIT] = pst_en_r;
        ctrl_val[`CFG_BME_BIT] = bus_watch_enable;
        ctrl_val[`CFG_BMT_MSB:`CFG_BMT_LSB] = bus_watch_timeout;
    end

    // reserved bits read as zero
    always @*
    begin
        rcfg_val = 16'h0000;
        rcfg_val[`CFG_RC_DRIVE_BIT] = drive_full;
        rcfg_val[`CFG_RC_MODE_BIT] = master;
    end

    always @*
    begin
        rdata_nxt = 16'h0000;
        case (sel)
            SEL_CTRL: rdata_nxt = ctrl_val;
            SEL_LPWR: rdata_nxt = {8'h00, lpwr_r};
            SEL_RCFG: rdata_nxt = rcfg_val;
            SEL_PID: rdata_nxt = PART_ID;
            SEL_TLCK: rdata_nxt = 16'h0000;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // answer chosen from the decode of the access now on the bus
    always @*
    begin
        ack_nxt = acc_ok;
        terr_nxt = BUS_SEL && !acc_ok;
    end

    // one-cycle answer: ack or transfer error the edge after the select
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rdata_r <= 16'h0000;
            ack_r <= 1'b0;
            terr_r <= 1'b0;
        end
        else
        begin
            ack_r <= ack_nxt;
            terr_r <= terr_nxt;
            // zero outside the ack cycle so stale data never leaks
            if (acc_ok && !BUS_WR)
                rdata_r <= rdata_nxt;
            else
                rdata_r <= 16'h0000;
        end
    end

    // registered so the watch counter never sees a shifter glitch
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            cycles_r <= `CFG_BMT_MAX >> `CFG_BMT_RST;
        else
            cycles_r <= cfg_bmt_cycles(bus_watch_timeout);
    end

    // every output but test_active comes straight from a flop
    assign BUS_RDATA = rdata_r;
    assign BUS_ACK = ack_r;
    assign BUS_TERR = terr_r;
    assign SIZE_PINS_ENABLE = size_en_r;
    assign PROC_STATUS_PINS_ENABLE = pst_en_r;
    assign BUS_WATCH_ENABLE = bus_watch_enable;
    assign BUS_WATCH_TIMEOUT = bus_watch_timeout;
    assign BUS_WATCH_CYCLES = cycles_r;
    assign PAD_DRIVE_STRENGTH = drive_full;
    assign MASTER_MODE = master;
    assign LOW_POWER_CTRL = lpwr_r;

endmodule

// ---- verilog/cfg_strap.v ----
`timescale 1ns/1ns
`include "cfg_defines.vh"

module cfg_strap
#(
    parameter HOLD_CYC = `CFG_OE_HOLD_OCLK
)
(
    // clock and reset
    input wire clk,
    input wire rst,
    // reset configuration inputs
    input wire reset_out,
    input wire reset_config_select_n,
    input wire [15:0] data_in,
    // resulting configuration
    output wire drive_full,
    output wire master_mode,
    output wire data_oe_n
);

    reg drive_r;
    reg mode_r;
    reg oe_n_r;
    reg [7:0] hold_r;

    assign drive_full = drive_r;
    assign master_mode = mode_r;
    assign data_oe_n = oe_n_r;

    // sampled on the clock while reset_output stands, never under the async reset
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            drive_r <= `CFG_DEF_DRIVE;
            mode_r <= `CFG_DEF_MODE;
            oe_n_r <= 1'b1;
            hold_r <= 8'h00;
        end
        else if (reset_out)
        begin
            oe_n_r <= 1'b1;
            hold_r <= 8'h00;
            if (!reset_config_select_n)
            begin
                drive_r <= data_in[`CFG_PIN_DRIVE];
                mode_r <= data_in[`CFG_PIN_MODE];
            end
            else
            begin
                drive_r <= `CFG_DEF_DRIVE;
                mode_r <= `CFG_DEF_MODE;
            end
        end
        else if (hold_r < HOLD_CYC[7:0])
        begin
            // keeps the pins released while the override circuit lets go
            hold_r <= hold_r + 8'h01;
        end
        else
        begin
            oe_n_r <= 1'b0;
        end
    end

endmodule

// ---- verilog/cfg_wonce.v ----
`timescale 1ns/1ns
`include "cfg_defines.vh"

module cfg_wonce
#(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
    // clock and reset
    input wire clk,
    input wire rst,
    // write side
    input wire wr,
    input wire free,
    input wire [W-1:0] wdata,
    // value
    output wire [W-1:0] q
);

    reg [W-1:0] val_r;
    reg done_r;

    assign q = val_r;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            val_r <= RST_VAL;
            done_r <= 1'b0;
        end
        else if (wr && (free || !done_r))
        begin
            val_r <= wdata;
            // a debug write leaves the field open afterwards
            done_r <= !free;
        end
    end

endmodule
